/* src/csf_map.svh */
// csf_map.svh: encodings, field slices, reset values and counts of the stack and frame unit
`ifndef CSF_MAP_SVH
`define CSF_MAP_SVH

// ****************************************
// instruction fields (word bit 15 is the leftmost instruction bit)
// ****************************************
`define CSF_GRP_F      15:13
`define CSF_AC_F       12:11
`define CSF_OPC_F      10:6
`define CSF_DEV_F      5:0
`define CSF_GROUP_IO   3'h3
`define CSF_DEV_STACK  6'h01

// ****************************************
// operation and control codes, opcode and control bits together
// ****************************************
`define CSF_OPC_PUSH   5'h0C
`define CSF_OPC_POP    5'h0E
`define CSF_OPC_LDSP   5'h08
`define CSF_OPC_LDFP   5'h00
`define CSF_OPC_RDSP   5'h0A
`define CSF_OPC_RDFP   5'h02
`define CSF_OPC_SAVE   5'h14
`define CSF_OPC_REST   5'h16

// ****************************************
// word layout, counts and reset values
// ****************************************
`define CSF_PTR_F      14:0
`define CSF_MSB        15
`define CSF_PAGE_F     7:0
`define CSF_PAGE_ZERO  8'h00
`define CSF_PTR_ONE    15'h0001
`define CSF_PTR_RST    15'h0000
`define CSF_WORD_RST   16'h0000
`define CSF_STEP_RST   3'h0
`define CSF_STEP_ONE   3'h1
`define CSF_STEP_TWO   3'h2
`define CSF_STEP_FP    3'h3
`define CSF_LAST_STEP  3'h4
`define CSF_AC3_SEL    2'h3

`endif

/* src/csf_pkg.sv */
// csf_pkg.sv: types shared by the stack and frame unit
package csf_pkg;

  typedef enum logic [1:0] {
    CSF_IDLE   = 2'h0,
    CSF_ACCESS = 2'h1
  } csf_state_t;

  typedef enum logic [3:0] {
    CSF_NONE = 4'h0,
    CSF_PUSH = 4'h1,
    CSF_POP  = 4'h2,
    CSF_LDSP = 4'h3,
    CSF_LDFP = 4'h4,
    CSF_RDSP = 4'h5,
    CSF_RDFP = 4'h6,
    CSF_SAVE = 4'h7,
    CSF_REST = 4'h8
  } csf_op_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [14:0] addr;
    logic [15:0] wdata;
  } csf_mem_req_t;

  typedef struct packed {
    logic        en;
    logic [1:0]  sel;
    logic [15:0] data;
  } csf_ac_wr_t;

endpackage

/* src/csf_stack_unit.sv */
// csf_stack_unit.sv: push, pop, pointer moves, frame save and frame restore
// Operation
// RULE1: push increments stack top, then writes the accumulator at the new address
// RULE2: pop loads accumulator from stack top address, then decrements stack top
// RULE3: load pointer ops copy accumulator bits 1-15 into stack top or frame base
// RULE4: read pointer ops put pointer in accumulator bits 1-15, bit 0 cleared
// RULE5: overflow lets the instruction finish, then requests interrupt if interrupts enabled
// RULE6: overflow means stack top bits 8-15 are zero after an increment
// RULE7: save frame checks overflow after every one of its increments
// RULE8: save frame pushes accumulators zero, one, two in order, incrementing first
// RULE9: fourth save push writes old frame base in bits 1-15, zero in bit 0
// RULE10: fifth save push writes carry in bit 0, accumulator three bits 1-15
// RULE11: save end copies stack top to frame base and accumulator three, bit 0 cleared
// RULE12: restore brings back accumulators, program counter, carry and both pointers
// RULE13: stack ops use the I/O layout with device code 1; no device uses it
// RULE14: stack top and frame base are 15-bit word address registers
// RULE15: restore copies frame base to stack top, loads carry/pc, pops in reverse
// RULE16: decode group 0-2, accumulator 3-4, op 5-7, control 8-9, device 10-15
// RULE17: each access is one word, finished before the next pointer update
`timescale 1ns/1ps
`default_nettype none
`include "csf_map.svh"

module csf_stack_unit (
  input  wire logic                  sys_clk_in,
  input  wire logic                  rst_n_in,
  input  wire logic                  instr_valid_in,
  input  wire logic [15:0]           instr_in,
  output logic                       instr_ready_out,
  output logic                       done_out,
  input  wire logic [3:0][15:0]      ac_in,
  input  wire logic                  carry_in,
  input  wire logic                  int_enable_in,
  output csf_pkg::csf_mem_req_t      mem_out,
  input  wire logic                  mem_ack_in,
  input  wire logic [15:0]           mem_rdata_in,
  output csf_pkg::csf_ac_wr_t        ac_wr_out,
  output logic                       carry_wr_out,
  output logic                       carry_val_out,
  output logic                       pc_wr_out,
  output logic [14:0]                pc_val_out,
  output logic                       stack_ovf_req_out,
  output logic [14:0]                stack_top_out,
  output logic [14:0]                frame_base_out
);

  // ****************************************
  // reset release
  // ****************************************
  logic rst_meta_r;
  logic rst_sync_r;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // ****************************************
  // decode
  // ****************************************
  function automatic csf_pkg::csf_op_t decode_op(input logic [15:0] ins);
    csf_pkg::csf_op_t op;
    op = csf_pkg::CSF_NONE;
    // only device code 1 in the I/O group belongs to this unit
    if (ins[`CSF_GRP_F] == `CSF_GROUP_IO && ins[`CSF_DEV_F] == `CSF_DEV_STACK) begin // RULE13 RULE16
      case (ins[`CSF_OPC_F])
        `CSF_OPC_PUSH: op = csf_pkg::CSF_PUSH;
        `CSF_OPC_POP:  op = csf_pkg::CSF_POP;
        `CSF_OPC_LDSP: op = csf_pkg::CSF_LDSP;
        `CSF_OPC_LDFP: op = csf_pkg::CSF_LDFP;
        `CSF_OPC_RDSP: op = csf_pkg::CSF_RDSP;
        `CSF_OPC_RDFP: op = csf_pkg::CSF_RDFP;
        `CSF_OPC_SAVE: op = csf_pkg::CSF_SAVE;
        `CSF_OPC_REST: op = csf_pkg::CSF_REST;
        default:       op = csf_pkg::CSF_NONE;
      endcase
    end
    return op;
  endfunction

  function automatic csf_pkg::csf_mem_req_t mk_mem(input logic        we,
                                                   input logic [14:0] addr,
                                                   input logic [15:0] wdata);
    csf_pkg::csf_mem_req_t m;
    m.req   = 1'b1;
    m.we    = we;
    m.addr  = addr;
    m.wdata = wdata;
    return m;
  endfunction

  // ****************************************
  // state
  // ****************************************
  csf_pkg::csf_state_t   state_r,   state_nxt;
  csf_pkg::csf_op_t      op_r,      op_nxt;
  logic [2:0]            step_r,    step_nxt;
  logic [1:0]            sel_r,     sel_nxt;
  logic [14:0]           sp_r,      sp_nxt;
  logic [14:0]           fp_r,      fp_nxt;
  logic                  ovf_r,     ovf_nxt;
  csf_pkg::csf_mem_req_t mem_r,     mem_nxt;
  csf_pkg::csf_ac_wr_t   ac_wr_r,   ac_wr_nxt;
  logic                  cwr_r,     cwr_nxt;
  logic                  cval_r,    cval_nxt;
  logic                  pwr_r,     pwr_nxt;
  logic [14:0]           pval_r,    pval_nxt;
  logic                  done_r,    done_nxt;
  logic                  irq_r,     irq_nxt;

  csf_pkg::csf_op_t      dec_op;
  logic [14:0]           sp_inc;
  logic [14:0]           sp_dec;
  logic [2:0]            rest_idx;
  logic [15:0]           save_word;

  assign dec_op = decode_op(instr_in);
  assign sp_inc = sp_r + `CSF_PTR_ONE;
  assign sp_dec = sp_r - `CSF_PTR_ONE;
  assign rest_idx = `CSF_LAST_STEP - step_r;

  // word for the next save push, selected by the step whose access is completing
  always_comb begin
    case (step_r)
      `CSF_STEP_RST: save_word = ac_in[1]; // RULE8
      `CSF_STEP_ONE: save_word = ac_in[2]; // RULE8
      `CSF_STEP_TWO: save_word = {1'b0, fp_r}; // RULE9
      default:       save_word = {carry_in, ac_in[`CSF_AC3_SEL][`CSF_PTR_F]}; // RULE10
    endcase
  end

  always_comb begin
    logic finish;
    finish    = 1'b0;
    state_nxt = state_r;
    op_nxt    = op_r;
    step_nxt  = step_r;
    sel_nxt   = sel_r;
    sp_nxt    = sp_r;
    fp_nxt    = fp_r;
    ovf_nxt   = ovf_r;
    mem_nxt   = mem_r;
    ac_wr_nxt = '0;
    cwr_nxt   = 1'b0;
    cval_nxt  = cval_r;
    pwr_nxt   = 1'b0;
    pval_nxt  = pval_r;
    done_nxt  = 1'b0;
    irq_nxt   = 1'b0;
    case (state_r)
      csf_pkg::CSF_IDLE: begin
        if (instr_valid_in && dec_op != csf_pkg::CSF_NONE) begin
          op_nxt   = dec_op;
          sel_nxt  = instr_in[`CSF_AC_F];
          step_nxt = `CSF_STEP_RST;
          ovf_nxt  = 1'b0;
          case (dec_op)
            csf_pkg::CSF_PUSH: begin
              sp_nxt    = sp_inc; // RULE1
              ovf_nxt   = sp_inc[`CSF_PAGE_F] == `CSF_PAGE_ZERO; // RULE6
              mem_nxt   = mk_mem(1'b1, sp_inc, ac_in[instr_in[`CSF_AC_F]]); // RULE1
              state_nxt = csf_pkg::CSF_ACCESS;
            end
            csf_pkg::CSF_POP: begin
              mem_nxt   = mk_mem(1'b0, sp_r, `CSF_WORD_RST); // RULE2
              state_nxt = csf_pkg::CSF_ACCESS;
            end
            csf_pkg::CSF_LDSP: begin
              sp_nxt = ac_in[instr_in[`CSF_AC_F]][`CSF_PTR_F]; // RULE3
              finish = 1'b1;
            end
            csf_pkg::CSF_LDFP: begin
              fp_nxt = ac_in[instr_in[`CSF_AC_F]][`CSF_PTR_F]; // RULE3
              finish = 1'b1;
            end
            csf_pkg::CSF_RDSP: begin
              ac_wr_nxt = '{en: 1'b1, sel: instr_in[`CSF_AC_F], data: {1'b0, sp_r}}; // RULE4
              finish    = 1'b1;
            end
            csf_pkg::CSF_RDFP: begin
              ac_wr_nxt = '{en: 1'b1, sel: instr_in[`CSF_AC_F], data: {1'b0, fp_r}}; // RULE4
              finish    = 1'b1;
            end
            csf_pkg::CSF_SAVE: begin
              sp_nxt    = sp_inc; // RULE8
              ovf_nxt   = sp_inc[`CSF_PAGE_F] == `CSF_PAGE_ZERO; // RULE7
              mem_nxt   = mk_mem(1'b1, sp_inc, ac_in[0]); // RULE8
              state_nxt = csf_pkg::CSF_ACCESS;
            end
            default: begin
              sp_nxt    = fp_r; // RULE15
              mem_nxt   = mk_mem(1'b0, fp_r, `CSF_WORD_RST); // RULE15
              state_nxt = csf_pkg::CSF_ACCESS;
            end
          endcase
        end
      end
      default: begin
        // one word per handshake; pointers move only when it completes
        if (mem_ack_in) begin // RULE17
          mem_nxt.req = 1'b0;
          case (op_r)
            csf_pkg::CSF_PUSH: finish = 1'b1;
            csf_pkg::CSF_POP: begin
              ac_wr_nxt = '{en: 1'b1, sel: sel_r, data: mem_rdata_in}; // RULE2
              sp_nxt    = sp_dec; // RULE2
              finish    = 1'b1;
            end
            csf_pkg::CSF_SAVE: begin
              if (step_r == `CSF_LAST_STEP) begin
                fp_nxt    = sp_r; // RULE11
                ac_wr_nxt = '{en: 1'b1, sel: `CSF_AC3_SEL, data: {1'b0, sp_r}}; // RULE11
                finish    = 1'b1;
              end else begin
                step_nxt = step_r + `CSF_STEP_ONE;
                sp_nxt   = sp_inc; // RULE8
                ovf_nxt  = ovf_r | (sp_inc[`CSF_PAGE_F] == `CSF_PAGE_ZERO); // RULE7 RULE6
                mem_nxt  = mk_mem(1'b1, sp_inc, save_word);
              end
            end
            default: begin
              sp_nxt = sp_dec; // RULE15
              if (step_r == `CSF_STEP_RST) begin
                cwr_nxt  = 1'b1; // RULE12
                cval_nxt = mem_rdata_in[`CSF_MSB];
                pwr_nxt  = 1'b1;
                pval_nxt = mem_rdata_in[`CSF_PTR_F];
              end else begin
                ac_wr_nxt = '{en: 1'b1, sel: rest_idx[1:0], data: mem_rdata_in}; // RULE12
              end
              // the word that lands in accumulator three is the saved frame base
              if (step_r == `CSF_STEP_ONE) begin
                fp_nxt = mem_rdata_in[`CSF_PTR_F]; // RULE12
              end
              if (step_r == `CSF_LAST_STEP) begin
                finish = 1'b1;
              end else begin
                step_nxt = step_r + `CSF_STEP_ONE;
                mem_nxt  = mk_mem(1'b0, sp_dec, `CSF_WORD_RST); // RULE15
              end
            end
          endcase
        end
      end
    endcase
    if (finish) begin
      state_nxt = csf_pkg::CSF_IDLE;
      done_nxt  = 1'b1;
      // the request comes out in the same cycle as done, never interrupts the sequence
      irq_nxt   = ovf_nxt & int_enable_in; // RULE5
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      state_r <= csf_pkg::CSF_IDLE;
      op_r    <= csf_pkg::CSF_NONE;
      step_r  <= `CSF_STEP_RST;
      sel_r   <= 2'h0;
      sp_r    <= `CSF_PTR_RST; // RULE14
      fp_r    <= `CSF_PTR_RST; // RULE14
      ovf_r   <= 1'b0;
      mem_r   <= '0;
      ac_wr_r <= '0;
      cwr_r   <= 1'b0;
      cval_r  <= 1'b0;
      pwr_r   <= 1'b0;
      pval_r  <= `CSF_PTR_RST;
      done_r  <= 1'b0;
      irq_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      op_r    <= op_nxt;
      step_r  <= step_nxt;
      sel_r   <= sel_nxt;
      sp_r    <= sp_nxt;
      fp_r    <= fp_nxt;
      ovf_r   <= ovf_nxt;
      mem_r   <= mem_nxt;
      ac_wr_r <= ac_wr_nxt;
      cwr_r   <= cwr_nxt;
      cval_r  <= cval_nxt;
      pwr_r   <= pwr_nxt;
      pval_r  <= pval_nxt;
      done_r  <= done_nxt;
      irq_r   <= irq_nxt;
    end
  end

  assign instr_ready_out   = state_r == csf_pkg::CSF_IDLE;
  assign done_out          = done_r;
  assign mem_out           = mem_r;
  assign ac_wr_out         = ac_wr_r;
  assign carry_wr_out      = cwr_r;
  assign carry_val_out     = cval_r;
  assign pc_wr_out         = pwr_r;
  assign pc_val_out        = pval_r;
  assign stack_ovf_req_out = irq_r;
  assign stack_top_out     = sp_r;
  assign frame_base_out    = fp_r;

  // ****************************************
  // checks
  // ****************************************
  logic take;
  assign take = instr_ready_out && instr_valid_in;

  push_write_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_r) // RULE1
    take && dec_op == csf_pkg::CSF_PUSH |=> mem_out.req && mem_out.we
      && mem_out.addr == $past(sp_r) + `CSF_PTR_ONE && sp_r == mem_out.addr)
    else $error("push did not write at incremented stack top");

  pop_load_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_r) // RULE2
    state_r == csf_pkg::CSF_ACCESS && op_r == csf_pkg::CSF_POP && mem_ack_in
      |=> ac_wr_out.en && ac_wr_out.data == $past(mem_rdata_in)
      && sp_r == $past(mem_out.addr) - `CSF_PTR_ONE)
    else $error("pop load or decrement wrong");

  load_sp_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_r) // RULE3
    take && dec_op == csf_pkg::CSF_LDSP
      |=> sp_r == $past(ac_in[instr_in[`CSF_AC_F]][`CSF_PTR_F]) && done_out)
    else $error("stack top load wrong");

  read_ptr_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_r) // RULE4
    take && dec_op == csf_pkg::CSF_RDFP
      |=> ac_wr_out.en && ac_wr_out.data == {1'b0, $past(fp_r)} && fp_r == $past(fp_r))
    else $error("frame base read wrong");

  ovf_after_done_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_r) // RULE5
    stack_ovf_req_out |-> done_out && $past(ovf_nxt))
    else $error("overflow request without completed push");

  ovf_detect_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_r) // RULE6
    state_r == csf_pkg::CSF_ACCESS && op_r == csf_pkg::CSF_PUSH && mem_ack_in
      && mem_out.addr[`CSF_PAGE_F] == `CSF_PAGE_ZERO && int_enable_in |=> stack_ovf_req_out)
    else $error("page crossing not reported");

  save_fp_word_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_r) // RULE9
    mem_out.req && op_r == csf_pkg::CSF_SAVE && step_r == `CSF_STEP_FP
      |-> mem_out.wdata == {1'b0, fp_r} && mem_out.addr == sp_r)
    else $error("saved frame base word wrong");

  save_end_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_r) // RULE11
    done_out && op_r == csf_pkg::CSF_SAVE
      |-> fp_r == sp_r && ac_wr_out.sel == `CSF_AC3_SEL && ac_wr_out.data == {1'b0, sp_r})
    else $error("save did not update frame base");

  rest_start_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_r) // RULE15
    take && dec_op == csf_pkg::CSF_REST |=> mem_out.req && !mem_out.we
      && mem_out.addr == $past(fp_r) && sp_r == $past(fp_r))
    else $error("restore did not start at frame base");

  one_access_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_r) // RULE17
    mem_out.req && !mem_ack_in |=> $stable(sp_r) && $stable(mem_out.addr))
    else $error("pointer moved during a pending access");

endmodule

`default_nettype wire

/* testbench/csf_stack_mem.sv */
// csf_stack_mem.sv: word memory that holds the stack and answers after a set delay
`timescale 1ns/1ps
`default_nettype none

module csf_stack_mem (
  input  wire logic                  sys_clk_in,
  input  wire logic                  rst_n_in,
  input  wire csf_pkg::csf_mem_req_t mem_in,
  input  wire logic [3:0]            wait_in,
  output logic                       ack_out,
  output logic [15:0]                rdata_out
);
  // ****************************************
  // storage and answer timing
  // ****************************************
  logic [15:0] mem [0:32767];
  logic [3:0]  cnt_r;

  // plain always: the bench reads stored words through the hierarchy
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_out   <= 1'b0;
      cnt_r     <= 4'h0;
      rdata_out <= 16'hA5A5;
    end else if (ack_out || !mem_in.req) begin
      ack_out   <= 1'b0;
      cnt_r     <= 4'h0;
      // a released data bus must not look like it still holds the last word
      rdata_out <= ~rdata_out;
    end else if (cnt_r == wait_in) begin
      ack_out <= 1'b1;
      if (mem_in.we) begin
        mem[mem_in.addr] <= mem_in.wdata;
      end else begin
        rdata_out <= mem[mem_in.addr];
      end
    end else begin
      cnt_r     <= cnt_r + 4'h1;
      rdata_out <= ~rdata_out;
    end
  end
endmodule

`default_nettype wire

/* testbench/csf_stack_unit_bench.sv */
// csf_stack_unit_bench.sv: self-checking bench for the stack and frame unit
`timescale 1ns/1ps
`default_nettype none
`include "csf_map.svh"

`define CHK(what, exp, got) begin checks_done++; if ((got) !== (exp)) begin mismatches++; \
  $display("unexpected %s expected %h seen %h", what, exp, got); end end

module csf_stack_unit_bench;
  logic                  sys_clk, rst_n, valid, carry, int_en, ack, ready, done;
  logic                  carry_wr, carry_val, pc_wr, ovf, got_carry;
  logic [15:0]           instr, rdata;
  logic [3:0][15:0]      ac;
  logic [3:0]            wait_c;
  logic [14:0]           pc_val, sp, fp, got_pc;
  logic [15:0]           got_ac [4];
  csf_pkg::csf_mem_req_t mem_req;
  csf_pkg::csf_ac_wr_t   ac_wr;
  int                    mismatches = 0;
  int                    checks_done = 0;
  int                    cycles = 0;
  int                    n_ac, n_cpc, n_ovf, n_done;

  csf_stack_unit csf_stack_unit_inst (
    .sys_clk_in(sys_clk), .rst_n_in(rst_n), .instr_valid_in(valid), .instr_in(instr),
    .instr_ready_out(ready), .done_out(done), .ac_in(ac), .carry_in(carry),
    .int_enable_in(int_en), .mem_out(mem_req), .mem_ack_in(ack), .mem_rdata_in(rdata),
    .ac_wr_out(ac_wr), .carry_wr_out(carry_wr), .carry_val_out(carry_val),
    .pc_wr_out(pc_wr), .pc_val_out(pc_val), .stack_ovf_req_out(ovf),
    .stack_top_out(sp), .frame_base_out(fp));

  csf_stack_mem csf_stack_mem_inst (
    .sys_clk_in(sys_clk), .rst_n_in(rst_n), .mem_in(mem_req), .wait_in(wait_c),
    .ack_out(ack), .rdata_out(rdata));

  // ****************************************
  // shared helpers
  // ****************************************
  function automatic logic [15:0] op(input logic [4:0] code, input logic [1:0] sel);
    return {`CSF_GROUP_IO, sel, code, `CSF_DEV_STACK};
  endfunction

  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // offers one instruction and gathers every pulse until done
  task automatic run(input logic [15:0] ins, input bit quiet);
    n_ac = 0;
    n_cpc = 0;
    n_ovf = 0;
    n_done = 0;
    got_ac = '{default: 'x};
    @(posedge sys_clk);
    valid <= 1'b1;
    instr <= ins;
    @(posedge sys_clk);
    valid <= 1'b0;
    for (int i = 0; i < 60 && n_done == 0; i++) begin
      @(negedge sys_clk);
      if (ac_wr.en === 1'b1) begin
        got_ac[ac_wr.sel] = ac_wr.data;
        n_ac++;
      end
      if (carry_wr === 1'b1) begin
        got_carry = carry_val;
        n_cpc++;
      end
      if (pc_wr === 1'b1) begin
        got_pc = pc_val;
        n_cpc++;
      end
      if (ovf === 1'b1) n_ovf++;
      if (done === 1'b1) n_done++;
    end
    @(negedge sys_clk);
    `CHK("done", quiet ? 0 : 1, n_done)
  endtask

  task automatic ptrs(input logic [14:0] s, input logic [14:0] f);
    @(posedge sys_clk);
    ac[0] <= {1'b1, s};
    ac[1] <= {1'b0, f};
    run(op(`CSF_OPC_LDSP, 2'h0), 0);
    run(op(`CSF_OPC_LDFP, 2'h1), 0);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_moves;
    @(posedge sys_clk);
    ac <= {16'h0000, 16'h0ABC, 16'hC321, 16'h0000};
    run(op(`CSF_OPC_LDSP, 2'h1), 0);
    run(op(`CSF_OPC_LDFP, 2'h2), 0);
    `CHK("stack_top", 15'h4321, sp)
    `CHK("frame_base", 15'h0ABC, fp)
    `CHK("ac_untouched", 0, n_ac)
    run(op(`CSF_OPC_RDSP, 2'h3), 0);
    `CHK("read_top", 16'h4321, got_ac[3])
    run(op(`CSF_OPC_RDFP, 2'h0), 0);
    `CHK("read_base", 16'h0ABC, got_ac[0])
    `CHK("top_kept", 15'h4321, sp)
    $display("test moves ended");
  endtask

  task automatic t_push_pop;
    ptrs(15'h0010, 15'h0000);
    @(posedge sys_clk);
    ac <= {16'h0000, 16'h1357, 16'hBEEF, 16'h0000};
    run(op(`CSF_OPC_PUSH, 2'h1), 0);
    `CHK("push_word", 16'hBEEF, csf_stack_mem_inst.mem[15'h0011])
    `CHK("push_top", 15'h0011, sp)
    @(posedge sys_clk);
    wait_c <= 4'h3;
    run(op(`CSF_OPC_PUSH, 2'h2), 0);
    `CHK("slow_push", 16'h1357, csf_stack_mem_inst.mem[15'h0012])
    run(op(`CSF_OPC_POP, 2'h3), 0);
    `CHK("pop_word", 16'h1357, got_ac[3])
    `CHK("pop_top", 15'h0011, sp)
    run(op(`CSF_OPC_POP, 2'h0), 0);
    `CHK("pop_word2", 16'hBEEF, got_ac[0])
    `CHK("pop_top2", 15'h0010, sp)
    $display("test push_pop ended");
  endtask

  task automatic t_overflow;
    logic [14:0] start [4] = '{15'h01FF, 15'h01FE, 15'h02FF, 15'h7FFF};
    logic        en [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
    int          exp_ovf [4] = '{1, 0, 0, 1};
    for (int k = 0; k < 4; k++) begin
      ptrs(start[k], 15'h0000);
      @(posedge sys_clk);
      int_en <= en[k];
      run(op(`CSF_OPC_PUSH, 2'h2), 0);
      `CHK("overflow", exp_ovf[k], n_ovf)
      `CHK("ovf_top", start[k] + 15'h0001, sp)
    end
    $display("test overflow ended");
  endtask

  task automatic t_frame;
    logic [15:0] words [3] = '{16'h1111, 16'h4444, 16'h3333};
    ptrs(15'h03FD, 15'h2222);
    @(posedge sys_clk);
    ac <= {16'h8765, 16'h3333, 16'h4444, 16'h1111};
    carry <= 1'b1;
    int_en <= 1'b1;
    wait_c <= 4'h2;
    run(op(`CSF_OPC_SAVE, 2'h0), 0);
    for (int k = 0; k < 3; k++) begin
      `CHK("save_word", words[k], csf_stack_mem_inst.mem[15'h03FE + k[14:0]])
    end
    `CHK("save_base", 16'h2222, csf_stack_mem_inst.mem[15'h0401])
    `CHK("save_ret", 16'h8765, csf_stack_mem_inst.mem[15'h0402])
    `CHK("save_ovf", 1, n_ovf)
    `CHK("save_fp", 15'h0402, fp)
    `CHK("save_ac3", 16'h0402, got_ac[3])
    @(posedge sys_clk);
    ac <= '0;
    carry <= 1'b0;
    run(op(`CSF_OPC_REST, 2'h0), 0);
    `CHK("rest_carry", 1'b1, got_carry)
    `CHK("rest_pc", 15'h0765, got_pc)
    `CHK("rest_ac3", 16'h2222, got_ac[3])
    `CHK("rest_ac2", 16'h3333, got_ac[2])
    `CHK("rest_ac1", 16'h4444, got_ac[1])
    `CHK("rest_ac0", 16'h1111, got_ac[0])
    `CHK("rest_sp", 15'h03FD, sp)
    `CHK("rest_fp", 15'h2222, fp)
    $display("test frame ended");
  endtask

  task automatic t_ignored;
    ptrs(15'h0020, 15'h0000);
    run({3'h3, 2'h0, `CSF_OPC_PUSH, 6'h02}, 1);
    run({3'h2, 2'h0, `CSF_OPC_PUSH, `CSF_DEV_STACK}, 1);
    `CHK("ignored_top", 15'h0020, sp)
    `CHK("ignored_write", 0, n_ac)
    $display("test ignored ended");
  endtask

  // ****************************************
  // clock, watchdog and main sequence
  // ****************************************
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // all scenarios need well under a thousand cycles
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      mismatches++;
      results();
    end
  end

  initial begin
    rst_n = 1'b0;
    valid = 1'b0;
    instr = '0;
    ac = '0;
    carry = 1'b0;
    int_en = 1'b0;
    wait_c = 4'h0;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    `CHK("reset_top", 15'h0000, sp)
    `CHK("reset_ready", 1'b1, ready)
    t_moves();
    t_push_pop();
    t_overflow();
    t_frame();
    t_ignored();
    results();
  end
endmodule

`default_nettype wire
